/* File: core/ccid_consts.svh */
// constants of the contactless card identification and secure messaging core
// assumes the reader link is sampled on clk_sys and rf reset drives rstn
// Overview of operation
// - fixed seven-byte identifier comes from a write-protected store, never written
// - first cascade answers 88h tag, identifier bytes zero to two, check byte
// - second cascade answers identifier bytes three to six, then check byte
// - first identifier byte holds the manufacturer identification code
// - random-identifier mode finishes anticollision in a single cascade
// - fresh three-byte random identifier after each rf reset, shown in anticollision
// - applications named by three-byte identifier, optional dedicated-file name
// - five data file types plus one transaction code file type
// - structure-changing commands run under automatic rollback protection
// - pending rollback completes on its own before any further command
// - backup file transactions commit all fields or none on power loss
// - three-pass mutual authentication fixes session security level
// - plain transfer allowed under legacy and second-generation messaging and with no session, refused under first revision
// - mac mode appends 4-byte mac legacy, 8-byte cmac otherwise
// - legacy encrypted transfer appends 16-bit crc then encrypts
// - other encrypted transfer appends 32-bit crc, plus cmac under second generation
// - legacy auth takes only two-key 3des, encrypt-only, enters legacy messaging
// - standard-format auth takes two- or three-key 3des, enters first-revision messaging
// - aes auth takes only aes keys, enters first-revision messaging
// - transaction-opening auth takes aes, enters second-generation messaging, opens transaction
// - follow-on auth takes aes, only after the opening one in a transaction
// - link supports rates up to 848 kbit/s toward the reader
// - long transfers chain with continuation status AFh
`ifndef CCID_CONSTS_SVH
`define CCID_CONSTS_SVH
`define CCID_CASCADE_TAG     8'h88
`define CCID_STATUS_MORE     8'haf
`define CCID_STATUS_OK       8'h00
`define CCID_STATUS_AUTHERR  8'hae
`define CCID_STATUS_PERMERR  8'h9d
`define CCID_MAC4_LEN        4'h4
`define CCID_CMAC_LEN        4'h8
`define CCID_CRC16_LEN       4'h2
`define CCID_CRC32_LEN       4'h4
`define CCID_AID_LEN         2'h3
`define CCID_FILE_TYPES      3'h6
`define CCID_RATE_KBPS       848
`define CCID_CLK_KHZ         100000
`define CCID_BIT_CYC         ((`CCID_CLK_KHZ) / (`CCID_RATE_KBPS))
`define CCID_ROLLBACK_CYC    8'h10
`endif

/* File: core/ccid_pkg.sv */
// types of the card identification and secure messaging core
// assumes ccid_consts.svh is on the include path
`default_nettype none
package ccid_pkg;
   typedef enum logic [2:0] {
      CCID_MSG_NONE = 3'b000,
      CCID_MSG_LEG  = 3'b001,
      CCID_MSG_REV1 = 3'b010,
      CCID_MSG_GEN2 = 3'b011
   } ccid_msg_t;
   typedef enum logic [2:0] {
      CCID_AUTH_LEG   = 3'b000,
      CCID_AUTH_STD   = 3'b001,
      CCID_AUTH_AES   = 3'b010,
      CCID_AUTH_TXOPN = 3'b011,
      CCID_AUTH_TXFOL = 3'b100
   } ccid_auth_t;
   typedef enum logic [1:0] {
      CCID_KEY_DES  = 2'b00,
      CCID_KEY_2TD  = 2'b01,
      CCID_KEY_3TD  = 2'b10,
      CCID_KEY_AES  = 2'b11
   } ccid_key_t;
   typedef enum logic [1:0] {
      CCID_COMM_PLAIN = 2'b00,
      CCID_COMM_MAC   = 2'b01,
      CCID_COMM_ENC   = 2'b11
   } ccid_comm_t;
   typedef struct packed {
      logic       req;
      ccid_auth_t cmd;
      ccid_key_t  key;
      logic       pass;
   } ccid_auth_req_t;
   typedef struct packed {
      logic       legal;
      logic [3:0] crcLen;
      logic [3:0] macLen;
      logic       encrypt;
   } ccid_frame_t;
endpackage
`default_nettype wire

/* File: core/ccid_id_seq.sv */
// anticollision answer sequencer: emits one cascade response byte by byte
// assumes the identifier and random bytes are stable while a cascade runs
`include "ccid_consts.svh"
`default_nettype none
module ccid_id_seq
   import ccid_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        start,
   input  wire logic [1:0]  level,
   input  wire logic        randMode,
   input  wire logic [55:0] uid,
   input  wire logic [23:0] rnd,
   output logic             byteValid,
   output logic [7:0]       byteData,
   output logic             done
);
   typedef struct packed {
      logic        busy;
      logic [2:0]  idx;
      logic [39:0] frame;
      logic        valid;
      logic [7:0]  data;
      logic        done;
   } ccid_seq_st_t;
   ccid_seq_st_t s_q, s_d;
   logic [31:0] body;

   always_comb begin
      // random mode also needs a cascade tag style lead byte; 08h marks a random id
      if (randMode) begin
         body = {8'h08, rnd};
      end else if (level == 2'h1) begin
         body = {`CCID_CASCADE_TAG, uid[55:32]};
      end else begin
         body = uid[31:0];
      end
   end

   always_comb begin
      s_d = s_q;
      s_d.valid = 1'b0;
      s_d.done = 1'b0;
      if (start && !s_q.busy) begin
         s_d.busy = 1'b1;
         s_d.idx = 3'h0;
         s_d.frame = {body, body[31:24] ^ body[23:16] ^ body[15:8] ^ body[7:0]};
      end else if (s_q.busy) begin
         s_d.valid = 1'b1;
         s_d.data = s_q.frame[39:32];
         s_d.frame = {s_q.frame[31:0], 8'h00};
         s_d.idx = s_q.idx + 3'h1;
         if (s_q.idx == 3'h4) begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign byteValid = s_q.valid;
   assign byteData = s_q.data;
   assign done = s_q.done;

   five_bytes_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (start && !s_q.busy) |-> ##6 done) else $error("cascade not five bytes");
endmodule
`default_nettype wire

/* File: core/ccid_card.sv */
// card side core: anticollision, session messaging state, framing, rollback
// assumes rf reset drives rstn and link signals come from the rf front end
`include "ccid_consts.svh"
`default_nettype none
module ccid_card
   import ccid_pkg::*;
#(
   parameter logic [7:0]  MFR_CODE = 8'h5a, // arbitrary value
   parameter logic [47:0] SERIAL   = 48'h0123_4567_89ab
)(
   input  wire logic            clk_sys,
   input  wire logic            rstn,
   input  wire logic            linkClk,
   input  wire logic            randCfg,
   input  wire logic            anticolReq,
   input  wire logic [1:0]      anticolLevel,
   input  wire ccid_auth_req_t  authReq,
   input  wire logic            authTxnNew,
   input  wire ccid_comm_t      commMode,
   input  wire logic            cmdReq,
   input  wire logic            cmdStruct,
   input  wire logic            cmdDone,
   input  wire logic            moreData,
   input  wire logic            commitReq,
   input  wire logic            tearPending,
   output logic                 idValid,
   output logic [7:0]           idByte,
   output logic                 idDone,
   output ccid_msg_t            msgGen,
   output logic                 authOk,
   output logic                 authFail,
   output logic                 txnOpen,
   output ccid_frame_t          frameFmt,
   output logic                 cmdGrant,
   output logic                 rollbackBusy,
   output logic                 shadowActive,
   output logic [7:0]           statusByte,
   output logic                 linkEdge
);
   typedef struct packed {
      logic [1:0]  lnkSync;
      logic        lnkPrev;
      logic        edgeQ;
      logic [15:0] lfsr;
      logic [23:0] rnd;
      logic        rndLatched;
      ccid_msg_t   msg;
      logic        aOk;
      logic        aFail;
      logic        txn;
      ccid_frame_t fmt;
      logic        journal;
      logic        shadow;
      logic        rbBusy;
      logic [7:0]  rbCnt;
      logic        grant;
      logic [7:0]  status;
   } ccid_state_t;
   ccid_state_t s_q, s_d;

   // identifier lives in a constant: nothing in this core can ever write it
   localparam logic [55:0] UID = {MFR_CODE, SERIAL};

   logic keyOk;
   ccid_msg_t newMsg;

   ccid_id_seq u_seq (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .start     (anticolReq && (s_q.rndLatched || !randCfg)),
      .level     (anticolLevel),
      .randMode  (randCfg),
      .uid       (UID),
      .rnd       (s_q.rnd),
      .byteValid (idValid),
      .byteData  (idByte),
      .done      (idDone)
   );

   always_comb begin
      keyOk = 1'b0;
      newMsg = CCID_MSG_NONE;
      unique case (authReq.cmd)
         CCID_AUTH_LEG: begin
            keyOk = (authReq.key == CCID_KEY_2TD);
            newMsg = CCID_MSG_LEG;
         end
         CCID_AUTH_STD: begin
            keyOk = (authReq.key == CCID_KEY_2TD) || (authReq.key == CCID_KEY_3TD);
            newMsg = CCID_MSG_REV1;
         end
         CCID_AUTH_AES: begin
            keyOk = (authReq.key == CCID_KEY_AES);
            newMsg = CCID_MSG_REV1;
         end
         CCID_AUTH_TXOPN: begin
            keyOk = (authReq.key == CCID_KEY_AES);
            newMsg = CCID_MSG_GEN2;
         end
         CCID_AUTH_TXFOL: begin
            keyOk = (authReq.key == CCID_KEY_AES) && s_q.txn;
            newMsg = CCID_MSG_GEN2;
         end
         default: begin
            keyOk = 1'b0;
            newMsg = CCID_MSG_NONE;
         end
      endcase
   end

   always_comb begin
      s_d = s_q;
      s_d.aOk = 1'b0;
      s_d.aFail = 1'b0;
      s_d.grant = 1'b0;
      // link clock only sampled; 848 kbit/s is far below the system rate
      s_d.lnkSync = {s_q.lnkSync[0], linkClk};
      s_d.lnkPrev = s_q.lnkSync[1];
      s_d.edgeQ = s_q.lnkSync[1] && !s_q.lnkPrev;
      s_d.lfsr = {s_q.lfsr[14:0], s_q.lfsr[15] ^ s_q.lfsr[13] ^ s_q.lfsr[12] ^ s_q.lfsr[10]};
      // random id taken once after reset, at the first link edge, whose timing gives the entropy
      if (!s_q.rndLatched && s_q.edgeQ) begin
         s_d.rnd = {s_q.lfsr, s_q.lfsr[7:0] ^ s_q.lfsr[15:8]};
         s_d.rndLatched = 1'b1;
      end
      if (authReq.req) begin
         s_d.msg = CCID_MSG_NONE;
         s_d.fmt = '0;
         if (authReq.cmd != CCID_AUTH_TXFOL) begin
            s_d.txn = 1'b0;
         end
         if (keyOk && authReq.pass) begin
            s_d.msg = newMsg;
            s_d.aOk = 1'b1;
            s_d.txn = (authReq.cmd == CCID_AUTH_TXOPN) || (authReq.cmd == CCID_AUTH_TXFOL);
            s_d.status = `CCID_STATUS_OK;
         end else begin
            s_d.aFail = 1'b1;
            s_d.status = `CCID_STATUS_AUTHERR;
         end
      end else begin
         if (authTxnNew) begin
            s_d.txn = 1'b0;
         end
         s_d.fmt = '0;
         unique case (commMode)
            CCID_COMM_PLAIN: begin
               s_d.fmt.legal = (s_q.msg == CCID_MSG_LEG) || (s_q.msg == CCID_MSG_GEN2)
                               || (s_q.msg == CCID_MSG_NONE);
            end
            CCID_COMM_MAC: begin
               s_d.fmt.legal = (s_q.msg != CCID_MSG_NONE);
               s_d.fmt.macLen = (s_q.msg == CCID_MSG_LEG) ? `CCID_MAC4_LEN : `CCID_CMAC_LEN;
            end
            CCID_COMM_ENC: begin
               s_d.fmt.legal = (s_q.msg != CCID_MSG_NONE);
               s_d.fmt.encrypt = 1'b1;
               if (s_q.msg == CCID_MSG_LEG) begin
                  s_d.fmt.crcLen = `CCID_CRC16_LEN;
               end else begin
                  s_d.fmt.crcLen = `CCID_CRC32_LEN;
                  s_d.fmt.macLen = (s_q.msg == CCID_MSG_GEN2) ? `CCID_CMAC_LEN : 4'h0;
               end
            end
            default: begin
               s_d.fmt.legal = 1'b0;
            end
         endcase
      end
      // rollback: a tear leaves the journal set; it is undone before anything runs
      if (s_q.journal && !s_q.rbBusy && tearPending) begin
         s_d.rbBusy = 1'b1;
         s_d.rbCnt = `CCID_ROLLBACK_CYC;
      end else if (s_q.rbBusy) begin
         s_d.rbCnt = s_q.rbCnt - 8'h01;
         if (s_q.rbCnt == 8'h01) begin
            s_d.rbBusy = 1'b0;
            s_d.journal = 1'b0;
            s_d.shadow = 1'b0;
         end
      end else if (cmdReq && !tearPending) begin
         s_d.grant = 1'b1;
         if (cmdStruct) begin
            s_d.journal = 1'b1;
         end
      end
      if (cmdDone && !s_q.rbBusy) begin
         s_d.journal = 1'b0;
         s_d.status = moreData ? `CCID_STATUS_MORE : `CCID_STATUS_OK;
      end
      // backup files: writes go to a shadow copy, only commit makes them visible
      if (commitReq && !s_q.rbBusy) begin
         s_d.shadow = 1'b0;
      end else if (s_q.grant && !cmdStruct) begin
         s_d.shadow = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
         s_q.lfsr <= 16'hace1;
      end else begin
         s_q <= s_d;
      end
   end

   assign msgGen = s_q.msg;
   assign authOk = s_q.aOk;
   assign authFail = s_q.aFail;
   assign txnOpen = s_q.txn;
   assign frameFmt = s_q.fmt;
   assign cmdGrant = s_q.grant;
   assign rollbackBusy = s_q.rbBusy;
   assign shadowActive = s_q.shadow;
   assign statusByte = s_q.status;
   assign linkEdge = s_q.edgeQ;

   // rollback and command gating

   no_grant_rb_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_q.rbBusy
      |-> ##1 !s_q.grant)
      else $error("command granted during rollback");

   // two runs of eight cover the sixteen busy cycles; keep in step with the rollback count
   rb_len_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      $rose(s_q.rbBusy)
      |-> s_q.rbBusy [*8] ##1 s_q.rbBusy [*8] ##1 !s_q.rbBusy)
      else $error("rollback length wrong");

   rb_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      $fell(s_q.rbBusy)
      |-> !s_q.journal && !s_q.shadow)
      else $error("rollback left journal or shadow");

   tear_block_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (cmdReq && tearPending)
      |=> !s_q.grant)
      else $error("command granted with tear pending");

   commit_clr_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (commitReq && !s_q.rbBusy)
      |=> !s_q.shadow)
      else $error("commit left shadow copy");

   chain_stat_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (cmdDone && moreData && !s_q.rbBusy)
      |=> s_q.status == `CCID_STATUS_MORE)
      else $error("chained answer lacks continuation");

   // authentication and session state

   leg_key_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (authReq.req && authReq.cmd == CCID_AUTH_LEG && authReq.key != CCID_KEY_2TD)
      |=> s_q.aFail)
      else $error("legacy auth took wrong key");

   std_msg_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (authReq.req && authReq.cmd == CCID_AUTH_STD && authReq.pass && authReq.key == CCID_KEY_3TD)
      |=> s_q.msg == CCID_MSG_REV1)
      else $error("standard auth level wrong");

   aes_key_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (authReq.req && authReq.cmd == CCID_AUTH_AES && authReq.key != CCID_KEY_AES)
      |=> !s_q.aOk)
      else $error("aes auth took wrong key");

   opn_txn_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_q.aOk && s_q.msg == CCID_MSG_GEN2
      |-> s_q.txn)
      else $error("gen2 auth without transaction");

   fol_need_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (authReq.req && authReq.cmd == CCID_AUTH_TXFOL && !s_q.txn)
      |=> s_q.aFail)
      else $error("follow-on auth outside transaction");

   fol_fail_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (authReq.req && authReq.cmd == CCID_AUTH_TXFOL && !authReq.pass)
      |=> $stable(s_q.txn))
      else $error("failed follow-on changed transaction");

   txn_close_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (!authReq.req && authTxnNew)
      |=> !s_q.txn)
      else $error("transaction not closed");

   ok_level_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_q.aOk
      |-> s_q.msg != CCID_MSG_NONE)
      else $error("auth passed without messaging level");

   drop_sess_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (authReq.req && !authReq.pass)
      |=> s_q.msg == CCID_MSG_NONE)
      else $error("session kept");

   auth_fmt_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      authReq.req
      |=> s_q.fmt == '0)
      else $error("frame format kept across auth");

   // framing; these only hold when no authentication lands in the same cycle

   mac_len_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (!authReq.req && commMode == CCID_COMM_MAC && s_q.msg == CCID_MSG_LEG)
      |=> s_q.fmt.macLen == 4'h4)
      else $error("legacy mac length wrong");

   rev1_cmac_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (!authReq.req && commMode == CCID_COMM_MAC && s_q.msg == CCID_MSG_REV1)
      |=> s_q.fmt.macLen == 4'h8)
      else $error("first revision cmac length wrong");

   plain_rev1_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (!authReq.req && commMode == CCID_COMM_PLAIN && s_q.msg == CCID_MSG_REV1)
      |=> !s_q.fmt.legal)
      else $error("plain allowed under first revision");

   leg_crc_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (!authReq.req && commMode == CCID_COMM_ENC && s_q.msg == CCID_MSG_LEG)
      |=> s_q.fmt.crcLen == 4'h2 && s_q.fmt.encrypt)
      else $error("legacy enc frame wrong");

   crc_len_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (!authReq.req && commMode == CCID_COMM_ENC && s_q.msg == CCID_MSG_GEN2)
      |=> s_q.fmt.crcLen == 4'h4 && s_q.fmt.macLen == 4'h8)
      else $error("gen2 enc frame wrong");

   // link sampling and random identifier

   edge_pulse_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_q.edgeQ
      |=> !s_q.edgeQ)
      else $error("link edge longer than one cycle");

   rnd_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_q.rndLatched
      |=> s_q.rndLatched && $stable(s_q.rnd))
      else $error("random identifier moved");

   // a zero state would freeze the generator and repeat one identifier forever
   lfsr_live_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_q.lfsr
      != 16'h0000)
      else $error("random generator stuck");
endmodule
`default_nettype wire

/* File: tb/ccid_reader_model.sv */
// reader side model: makes the link clock only while a frame is on air
// assumes the bench raises frameOn for the length of each frame
`default_nettype none
module ccid_reader_model (
   input  wire logic frameOn,
   output var  logic linkClk
);
   timeunit 1ns;
   timeprecision 100ps;
   parameter int HALF_NS = 40;
   // clock stands low between frames, as the field carries no edges then
   initial begin
      linkClk = 1'b0;
      forever begin
         #(HALF_NS);
         linkClk = frameOn ? ~linkClk : 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench of the card core: anticollision, auth, framing, rollback
// assumes ccid_pkg is compiled first and ccid_consts.svh is on the include path
`include "ccid_consts.svh"
`default_nettype none
module testbench
   import ccid_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0]  MFR = 8'h3c; // arbitrary value
   localparam logic [47:0] SER = 48'h1122_3344_5566;
   logic clk_sys, rstn, frameOn, linkClk, randCfg, anticolReq, authTxnNew, cmdReq, cmdStruct;
   logic cmdDone, moreData, commitReq, tearPending, idValid, idDone, authOk, authFail, txnOpen;
   logic cmdGrant, rollbackBusy, shadowActive, linkEdge, txnExp;
   logic [1:0]     anticolLevel;
   logic [7:0]     idByte, statusByte;
   ccid_auth_req_t authReq;
   ccid_comm_t     commMode;
   ccid_msg_t      msgGen;
   ccid_frame_t    frameFmt;
   int n_errors = 0, checked = 0, nGrant = 0, nEdge = 0, nBusy = 0, seed = 82;

   ccid_card #(.MFR_CODE(MFR), .SERIAL(SER)) ccid_card_i (
      .clk_sys(clk_sys), .rstn(rstn), .linkClk(linkClk), .randCfg(randCfg),
      .anticolReq(anticolReq), .anticolLevel(anticolLevel), .authReq(authReq),
      .authTxnNew(authTxnNew), .commMode(commMode), .cmdReq(cmdReq), .cmdStruct(cmdStruct),
      .cmdDone(cmdDone), .moreData(moreData), .commitReq(commitReq), .tearPending(tearPending),
      .idValid(idValid), .idByte(idByte), .idDone(idDone), .msgGen(msgGen), .authOk(authOk),
      .authFail(authFail), .txnOpen(txnOpen), .frameFmt(frameFmt), .cmdGrant(cmdGrant),
      .rollbackBusy(rollbackBusy), .shadowActive(shadowActive), .statusByte(statusByte),
      .linkEdge(linkEdge));
   ccid_reader_model ccid_reader_model_i (.frameOn(frameOn), .linkClk(linkClk));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (cmdGrant === 1'b1) nGrant <= nGrant + 1;
      if (linkEdge === 1'b1) nEdge <= nEdge + 1;
      if (rollbackBusy === 1'b1) nBusy <= nBusy + 1;
   end

   task automatic tally_and_finish;
      if (n_errors == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   function automatic logic acceptKey(ccid_auth_t c, ccid_key_t k, logic txn);
      case (c)
         CCID_AUTH_LEG:                  return k == CCID_KEY_2TD;
         CCID_AUTH_STD:                  return k == CCID_KEY_2TD || k == CCID_KEY_3TD;
         CCID_AUTH_AES, CCID_AUTH_TXOPN: return k == CCID_KEY_AES;
         default:                        return k == CCID_KEY_AES && txn;
      endcase
   endfunction
   function automatic ccid_msg_t genOf(ccid_auth_t c);
      if (c == CCID_AUTH_LEG) return CCID_MSG_LEG;
      if (c == CCID_AUTH_STD || c == CCID_AUTH_AES) return CCID_MSG_REV1;
      return CCID_MSG_GEN2;
   endfunction
   function automatic ccid_frame_t frameOf(ccid_msg_t g, ccid_comm_t m);
      ccid_frame_t f;
      f = '0;
      f.legal = 1'b1;
      if (m == CCID_COMM_PLAIN) f.legal = (g != CCID_MSG_REV1);
      else if (m == CCID_COMM_MAC) f.macLen = (g == CCID_MSG_LEG) ? 4'h4 : 4'h8;
      else begin
         f.encrypt = 1'b1;
         f.crcLen  = (g == CCID_MSG_LEG) ? 4'h2 : 4'h4;
         f.macLen  = (g == CCID_MSG_GEN2) ? 4'h8 : 4'h0;
      end
      return f;
   endfunction

   task automatic do_reset;
      @(posedge clk_sys) rstn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      txnExp = 1'b0;
      @(posedge clk_sys);
   endtask
   // random bytes cannot be predicted, so only the lead byte and check byte are compared
   task automatic cascade(input logic [1:0] lvl, input logic [39:0] exp, input logic known);
      logic [39:0] got;
      int n;
      got = '0;
      n = 0;
      @(posedge clk_sys) begin
         anticolLevel <= lvl;
         anticolReq   <= 1'b1;
      end
      @(posedge clk_sys) anticolReq <= 1'b0;
      for (int i = 0; i < 12; i++) begin
         #1;
         if (idValid === 1'b1) begin
            got = {got[31:0], idByte};
            n++;
         end
         if (idDone === 1'b1) break;
         @(posedge clk_sys);
      end
      check(n == 5, "cascade byte count");
      check(got[7:0] === (got[39:32] ^ got[31:24] ^ got[23:16] ^ got[15:8]), "check byte");
      if (known) check(got === exp, "cascade bytes");
      else check(got[39:32] === 8'h08, "random lead byte");
   endtask
   task automatic auth(input ccid_auth_t c, input ccid_key_t k, input logic p);
      logic ok;
      int i;
      ok = p && acceptKey(c, k, txnExp);
      @(posedge clk_sys) authReq <= '{1'b1, c, k, p};
      @(posedge clk_sys) authReq.req <= 1'b0;
      for (i = 0; i < 4; i++) begin
         #1;
         if ((authOk | authFail) === 1'b1) break;
         @(posedge clk_sys);
      end
      if (i == 4) begin
         n_errors++;
         tally_and_finish();
      end
      check(authOk === ok && authFail === !ok, "auth verdict");
      check(msgGen === (ok ? genOf(c) : CCID_MSG_NONE), "messaging generation");
      if (ok) txnExp = (c == CCID_AUTH_TXOPN) || (c == CCID_AUTH_TXFOL);
      else if (c != CCID_AUTH_TXFOL) txnExp = 1'b0;
      check(txnOpen === txnExp, "transaction state");
      for (int m = 0; m < 3; m++) begin
         @(posedge clk_sys) commMode <= (m == 2) ? CCID_COMM_ENC : ccid_comm_t'(m);
         repeat (3) @(posedge clk_sys);
         #1;
         if (ok || commMode == CCID_COMM_PLAIN)
            check(frameFmt === frameOf(msgGen, commMode), "frame format");
      end
      if (ok && c == CCID_AUTH_TXFOL) begin
         @(posedge clk_sys) authTxnNew <= 1'b1;
         @(posedge clk_sys) authTxnNew <= 1'b0;
         #1;
         txnExp = 1'b0;
         check(txnOpen === 1'b0, "transaction close");
      end
   endtask

   initial begin
      int g, i;
      {rstn, frameOn, randCfg, anticolReq, authTxnNew, cmdReq, cmdStruct} = '0;
      {cmdDone, moreData, commitReq, tearPending, anticolLevel, txnExp} = '0;
      authReq = '0;
      commMode = CCID_COMM_PLAIN;
      do_reset();
      cascade(2'd1, {8'h88, MFR, SER[47:32], 8'h88 ^ MFR ^ SER[47:40] ^ SER[39:32]}, 1'b1);
      cascade(2'd2, {SER[31:0], SER[31:24] ^ SER[23:16] ^ SER[15:8] ^ SER[7:0]}, 1'b1);
      auth(CCID_AUTH_TXFOL, CCID_KEY_AES, 1'b1);
      auth(CCID_AUTH_TXOPN, CCID_KEY_AES, 1'b1);
      auth(CCID_AUTH_TXFOL, CCID_KEY_AES, 1'b1);
      auth(CCID_AUTH_AES, CCID_KEY_AES, 1'b0);
      auth(CCID_AUTH_LEG, CCID_KEY_2TD, 1'b1);
      auth(CCID_AUTH_STD, CCID_KEY_3TD, 1'b1);
      for (int n = 0; n < 40; n++)
         auth(ccid_auth_t'(3'($unsigned($random(seed)) % 5)), ccid_key_t'(2'($random(seed))),
              ($random(seed) & 3) != 0);
      // a granted structural command opens the journal; a tear then forces a rollback
      @(posedge clk_sys) {cmdReq, cmdStruct} <= 2'b11;
      @(posedge clk_sys) cmdReq <= 1'b0;
      @(posedge clk_sys) tearPending <= 1'b1;
      #1;
      g = nGrant;
      check(g == 1, "structural command grant");
      @(posedge clk_sys) cmdReq <= 1'b1;
      @(posedge clk_sys) cmdReq <= 1'b0;
      repeat (4) @(posedge clk_sys);
      check(nGrant == g, "grant during pending rollback");
      check(rollbackBusy === 1'b1, "rollback not started");
      tearPending <= 1'b0;
      for (i = 0; i < 40; i++) begin
         @(posedge clk_sys);
         #1;
         if (rollbackBusy === 1'b0) break;
      end
      check(i < 40, "rollback never ended");
      check(nBusy == `CCID_ROLLBACK_CYC, "rollback length");
      @(posedge clk_sys) {cmdReq, cmdStruct, moreData} <= 3'b101;
      @(posedge clk_sys) cmdReq <= 1'b0;
      @(posedge clk_sys) cmdDone <= 1'b1;
      @(posedge clk_sys) cmdDone <= 1'b0;
      #1;
      check(nGrant == g + 1, "grant after rollback");
      check(statusByte === `CCID_STATUS_MORE, "chain status");
      check(shadowActive === 1'b1, "backup writes not shadowed");
      @(posedge clk_sys) {cmdDone, commitReq, moreData} <= 3'b110;
      @(posedge clk_sys) {cmdDone, commitReq} <= 2'b00;
      #1;
      check(statusByte === `CCID_STATUS_OK && shadowActive === 1'b0, "commit");
      randCfg <= 1'b1;
      do_reset();
      frameOn <= 1'b1;
      g = nEdge;
      repeat (30) @(posedge clk_sys);
      frameOn <= 1'b0;
      check(nEdge > g, "link edge");
      cascade(2'd1, '0, 1'b0);
      tally_and_finish();
   end
   initial begin
      #900us;
      n_errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
